// ===== tlp_pkg.sv
// Shared constants for the translation lookup and protection block
`default_nettype none
package tlp_pkg;
  // ==========================================================
  // Geometry
  localparam int WAYS = 4;
  localparam int SETS = 32;
  localparam int SET_W = 5;
  localparam int WAY_W = 2;
  localparam int ENTRIES = 128;
  localparam int TAG_W = 8;
  localparam int PFN_W = 22;
  // ==========================================================
  // Entry layout in the set memory
  localparam int ENTRY_W = 53;
  localparam int E_VHI_MSB = 52;
  localparam int E_VHI_LSB = 38;
  localparam int E_VLO_LSB = 36;
  localparam int E_TAG_LSB = 28;
  localparam int E_GLOBAL = 27;
  localparam int E_SIZE = 26;
  localparam int E_PFN_LSB = 4;
  localparam int E_KEY_LSB = 2;
  localparam int E_CACHE = 1;
  localparam int E_WRITTEN = 0;
  // ==========================================================
  // Register bus map, word indices (byte address bits 7:2)
  localparam int ADDR_W = 8;
  localparam logic [5:0] R_CTRL = 6'h00;
  localparam logic [5:0] R_PEHI = 6'h01;
  localparam logic [5:0] R_ENT_HI = 6'h02;
  localparam logic [5:0] R_ENT_LO = 6'h03;
  localparam logic [5:0] R_ENT_CMD = 6'h04;
  localparam logic [5:0] R_RESULT = 6'h05;
  localparam logic [5:0] R_FAULT_VA = 6'h06;
  // Control word bits
  localparam int C_ENABLE = 0;
  localparam int C_HASH = 1;
  localparam int C_SINGLE = 2;
  localparam int C_FLUSH = 3;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // Entry low word bits
  localparam int L_VALID = 8;
  // Entry command word: way in 6:5, set in 4:0
  localparam int K_WAY_LSB = 5;
  // Page entry high keeps page number and process tag only
  localparam logic [31:0] PEHI_MASK = 32'hfffffcff;
  localparam logic [31:0] ENT_LO_MASK = 32'hfffffd7f;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Address areas by top three bits
  localparam logic [2:0] AREA_P1 = 3'h4;
  localparam logic [2:0] AREA_P3 = 3'h6;
endpackage
`default_nettype wire

// ===== tlp_set_ram.sv
// Set memory holding all four ways of every set, registered read
`default_nettype none
module tlp_set_ram (
  // Clock
  input wire logic aclk,
  // Entry write
  input wire logic wr_en,
  input wire logic [tlp_pkg::WAY_W-1:0] wr_way,
  input wire logic [tlp_pkg::SET_W-1:0] wr_set,
  input wire logic [tlp_pkg::ENTRY_W-1:0] wr_data,
  // Set read, all ways at once
  input wire logic [tlp_pkg::SET_W-1:0] rd_set,
  output logic [tlp_pkg::WAYS*tlp_pkg::ENTRY_W-1:0] rd_data
);
  logic [tlp_pkg::ENTRY_W-1:0] mem_q [tlp_pkg::WAYS][tlp_pkg::SETS];

  // ==========================================================
  // Storage; no reset, the in-use bits live outside
  always_ff @(posedge aclk)
  begin
    if (wr_en)
    begin
      mem_q[wr_way][wr_set] <= wr_data;
    end
    rd_data <= {mem_q[3][rd_set], mem_q[2][rd_set], mem_q[1][rd_set], mem_q[0][rd_set]};
  end
endmodule // tlp_set_ram
`default_nettype wire

// ===== tlp_lookup.sv
// Four-way translation lookup with page protection checks
//
// Contract
// - 128 entries, four ways of 32 sets
// - Page number is 22 or 20 top bits
// - Set index bits not kept in tags
// - Hash off: index is page bits 16:12
// - Hash on: XOR with process tag 4:0
// - Every translated fetch or data access looks up
// - Four ways compared; hit needs in-use bit
// - Page bits 11:10 compared for small pages
// - Global pages skip process tag compare
// - Single space and privileged skip tag compare
// - Power-on clears in-use bits, manual keeps
// - Rights key decodes read/write per mode
// - Write to unwritten page raises exception
// - Translated access cacheable only when entry allows caching
// - 22-bit frame, bits 11:10 unused large
// - Hit entry bits decide exception and caching
// - Process tag is eight bits
// - Only P0, P3, U0 consult lookup
// - No way hits: miss exception
`default_nettype none
module tlp_lookup (
  // Clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic manual_rst_n,
  // AXI4-Lite write
  input wire logic [tlp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [tlp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Access request from the core
  input wire logic req_valid,
  input wire logic [31:0] req_vaddr,
  input wire logic req_write,
  input wire logic req_fetch,
  input wire logic privilege_mode_bit,
  // Translation answer
  output logic rsp_valid,
  output logic [31:0] rsp_paddr,
  output logic rsp_translated,
  output logic rsp_fetch,
  output logic rsp_hit,
  output logic rsp_miss,
  output logic rsp_prot_viol,
  output logic rsp_initial_write,
  output logic rsp_cacheable
);
  localparam int EW = tlp_pkg::ENTRY_W;

  // ==========================================================
  // Helpers
  function automatic logic [tlp_pkg::SET_W-1:0] set_of(input logic [31:0] va,
      input logic [7:0] tag, input logic hash);
    logic [tlp_pkg::SET_W-1:0] s;
    s = va[16:12];
    if (hash)
    begin
      s = va[16:12] ^ tag[4:0];
    end
    return s;
  endfunction

  function automatic logic way_match(input logic [EW-1:0] e, input logic [31:0] va,
      input logic [7:0] tag, input logic skip_tag);
    logic hi_ok;
    logic lo_ok;
    logic tag_ok;
    hi_ok = e[tlp_pkg::E_VHI_MSB:tlp_pkg::E_VHI_LSB] == va[31:17];
    lo_ok = e[tlp_pkg::E_SIZE] || (e[tlp_pkg::E_VLO_LSB +: 2] == va[11:10]);
    tag_ok = skip_tag || e[tlp_pkg::E_GLOBAL]
      || (e[tlp_pkg::E_TAG_LSB +: tlp_pkg::TAG_W] == tag);
    return hi_ok && lo_ok && tag_ok;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
      input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Register bus slave
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_held_q, w_held_q;
  logic [tlp_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [2:0] ctrl_q;
  logic [31:0] pehi_q, ent_hi_q, ent_lo_q, fault_va_q;
  logic [6:0] result_q;
  logic [tlp_pkg::ENTRIES-1:0] valid_q;

  wire logic [5:0] wr_idx = awaddr_q[7:2];
  wire logic [5:0] rd_idx = s_axi_araddr[7:2];
  wire logic wr_fire = aw_held_q && w_held_q && !bvalid_q;
  wire logic wr_known = wr_idx <= tlp_pkg::R_FAULT_VA;
  wire logic rd_known = rd_idx <= tlp_pkg::R_FAULT_VA;
  wire logic [31:0] ctrl_new = merge({29'h0, ctrl_q}, wdata_q, wstrb_q);
  // Flush reads back as zero, so it is a pulse only
  wire logic flush = wr_fire && wr_idx == tlp_pkg::R_CTRL && ctrl_new[tlp_pkg::C_FLUSH];
  wire logic load = wr_fire && wr_idx == tlp_pkg::R_ENT_CMD;
  wire logic [6:0] cmd_new = 7'(merge(32'h0, wdata_q, wstrb_q));
  wire logic [tlp_pkg::WAY_W-1:0] ld_way = cmd_new[tlp_pkg::K_WAY_LSB +: 2];
  wire logic [tlp_pkg::SET_W-1:0] ld_set = cmd_new[4:0];
  // Set index bits 16:12 are dropped from the stored tag
  wire logic [EW-1:0] ld_entry = {ent_hi_q[31:17], ent_hi_q[11:10], ent_hi_q[7:0],
    ent_lo_q[1], ent_lo_q[4], ent_lo_q[31:10], ent_lo_q[6:5], ent_lo_q[3], ent_lo_q[2]};

  // Read data selection
  wire logic [31:0] rd_word =
    rd_idx == tlp_pkg::R_CTRL ? {29'h0, ctrl_q} :
    rd_idx == tlp_pkg::R_PEHI ? pehi_q :
    rd_idx == tlp_pkg::R_ENT_HI ? ent_hi_q :
    rd_idx == tlp_pkg::R_ENT_LO ? ent_lo_q :
    rd_idx == tlp_pkg::R_RESULT ? {25'h0, result_q} :
    rd_idx == tlp_pkg::R_FAULT_VA ? fault_va_q : 32'h0;

  // Write channel handshakes; address and data may come in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= tlp_pkg::RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else if (bvalid_q && s_axi_bready)
    begin
      bvalid_q <= 1'b0;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
    end
    else
    begin
      if (s_axi_awvalid && awready_q)
      begin
        awaddr_q <= s_axi_awaddr;
        aw_held_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_held_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? tlp_pkg::RESP_OKAY : tlp_pkg::RESP_SLVERR;
      end
    end
  end

  // Read channel; one answer per address, one cycle later
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= tlp_pkg::RESP_OKAY;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
    else if (s_axi_arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_known ? tlp_pkg::RESP_OKAY : tlp_pkg::RESP_SLVERR;
    end
  end

  // Software registers; manual reset clears control, page entry high and both entry words
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !manual_rst_n)
    begin
      ctrl_q <= tlp_pkg::CTRL_RST;
      pehi_q <= '0;
      ent_hi_q <= '0;
      ent_lo_q <= '0;
    end
    else if (wr_fire)
    begin
      if (wr_idx == tlp_pkg::R_CTRL)
        ctrl_q <= ctrl_new[2:0];
      if (wr_idx == tlp_pkg::R_PEHI)
        pehi_q <= merge(pehi_q, wdata_q, wstrb_q) & tlp_pkg::PEHI_MASK;
      if (wr_idx == tlp_pkg::R_ENT_HI)
        ent_hi_q <= merge(ent_hi_q, wdata_q, wstrb_q) & tlp_pkg::PEHI_MASK;
      if (wr_idx == tlp_pkg::R_ENT_LO)
        ent_lo_q <= merge(ent_lo_q, wdata_q, wstrb_q) & tlp_pkg::ENT_LO_MASK;
    end
  end

  // In-use bits: power-on reset and flush clear them, manual reset does not
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      valid_q <= '0;
    else if (flush)
      valid_q <= '0;
    else if (load)
      valid_q[{ld_way, ld_set}] <= ent_lo_q[tlp_pkg::L_VALID];
  end

  // ==========================================================
  // Lookup stage 1: area decode and set index
  wire logic [2:0] area = req_vaddr[31:29];
  wire logic in_mapped = !req_vaddr[31] || area == tlp_pkg::AREA_P3;
  wire logic [tlp_pkg::SET_W-1:0] req_set =
    set_of(req_vaddr, pehi_q[7:0], ctrl_q[tlp_pkg::C_HASH]);
  logic s1_valid_q, s1_xlate_q, s1_write_q, s1_fetch_q, s1_priv_q, s1_skip_q, s1_cache_q;
  logic [31:0] s1_va_q;
  logic [7:0] s1_tag_q;
  logic [tlp_pkg::SET_W-1:0] s1_set_q;
  logic [tlp_pkg::WAYS*EW-1:0] ram_rd;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !manual_rst_n)
    begin
      s1_valid_q <= 1'b0;
      s1_xlate_q <= 1'b0;
      s1_write_q <= 1'b0;
      s1_fetch_q <= 1'b0;
      s1_priv_q <= 1'b0;
      s1_skip_q <= 1'b0;
      s1_cache_q <= 1'b0;
      s1_va_q <= '0;
      s1_tag_q <= '0;
      s1_set_q <= '0;
    end
    else
    begin
      s1_valid_q <= req_valid;
      s1_xlate_q <= req_valid && ctrl_q[tlp_pkg::C_ENABLE] && in_mapped;
      s1_write_q <= req_write;
      s1_fetch_q <= req_fetch;
      s1_priv_q <= privilege_mode_bit;
      s1_skip_q <= ctrl_q[tlp_pkg::C_SINGLE] && privilege_mode_bit;
      s1_cache_q <= req_vaddr[31:29] == tlp_pkg::AREA_P1 || !req_vaddr[31]
        || area == tlp_pkg::AREA_P3;
      s1_va_q <= req_vaddr;
      s1_tag_q <= pehi_q[7:0];
      s1_set_q <= req_set;
    end
  end

  tlp_set_ram u_ram (
    .aclk(aclk),
    .wr_en(load),
    .wr_way(ld_way),
    .wr_set(ld_set),
    .wr_data(ld_entry),
    .rd_set(req_set),
    .rd_data(ram_rd)
  );

  // ==========================================================
  // Lookup stage 2: compare all ways, check the winning entry
  logic [EW-1:0] ent [tlp_pkg::WAYS];
  logic [tlp_pkg::WAYS-1:0] hit_vec;
  for (genvar w = 0; w < tlp_pkg::WAYS; w++)
  begin : g_way
    assign ent[w] = ram_rd[w*EW +: EW];
    assign hit_vec[w] = valid_q[{2'(w), s1_set_q}]
      && way_match(ent[w], s1_va_q, s1_tag_q, s1_skip_q);
  end

  // Multi-way hits are software's fault; lowest way wins
  wire logic any_hit = |hit_vec;
  wire logic [1:0] way_sel = hit_vec[0] ? 2'h0 : hit_vec[1] ? 2'h1 : hit_vec[2] ? 2'h2 : 2'h3;
  wire logic [EW-1:0] sel = ent[way_sel];
  wire logic [1:0] key = sel[tlp_pkg::E_KEY_LSB +: 2];
  wire logic [21:0] pfn = sel[tlp_pkg::E_PFN_LSB +: tlp_pkg::PFN_W];
  // User needs key bit 1, writes need key bit 0
  wire logic x_prot = any_hit && ((!s1_priv_q && !key[1]) || (s1_write_q && !key[0]));
  wire logic x_initw = any_hit && !x_prot && s1_write_q
    && !sel[tlp_pkg::E_WRITTEN];
  wire logic x_cache = any_hit && !x_prot && !x_initw && sel[tlp_pkg::E_CACHE];
  // Large pages drop frame bits 11:10 and pass the offset through
  wire logic [31:0] x_pa = !any_hit ? 32'h0 :
    sel[tlp_pkg::E_SIZE] ? {pfn[21:2], s1_va_q[11:0]} : {pfn, s1_va_q[9:0]};
  wire logic x_miss = s1_xlate_q && !any_hit;

  // Answer registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !manual_rst_n)
    begin
      rsp_valid <= 1'b0;
      rsp_paddr <= '0;
      rsp_translated <= 1'b0;
      rsp_fetch <= 1'b0;
      rsp_hit <= 1'b0;
      rsp_miss <= 1'b0;
      rsp_prot_viol <= 1'b0;
      rsp_initial_write <= 1'b0;
      rsp_cacheable <= 1'b0;
    end
    else
    begin
      rsp_valid <= s1_valid_q;
      rsp_translated <= s1_xlate_q;
      rsp_fetch <= s1_fetch_q;
      rsp_hit <= s1_xlate_q && any_hit;
      rsp_miss <= x_miss;
      rsp_prot_viol <= s1_xlate_q && x_prot;
      rsp_initial_write <= s1_xlate_q && x_initw;
      rsp_cacheable <= s1_valid_q && (s1_xlate_q ? x_cache : s1_cache_q);
      rsp_paddr <= s1_xlate_q ? x_pa : {3'h0, s1_va_q[28:0]};
    end
  end

  // Last outcome and faulting address for software
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !manual_rst_n)
    begin
      result_q <= '0;
      fault_va_q <= '0;
    end
    else if (s1_xlate_q)
    begin
      result_q <= {x_cache, way_sel, x_initw, x_prot, x_miss, any_hit};
      if (x_miss || x_prot || x_initw)
        fault_va_q <= s1_va_q;
    end
  end

  // Bus outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ==========================================================
  // Checks
  property p_latency;
    @(posedge aclk) disable iff (!aresetn || !manual_rst_n)
    req_valid |-> ##2 rsp_valid;
  endproperty
  a_latency: assert property (p_latency) else $error("answer not two cycles later");

  property p_index;
    @(posedge aclk) disable iff (!aresetn || !manual_rst_n)
    req_valid && !ctrl_q[tlp_pkg::C_HASH] |=> s1_set_q == $past(req_vaddr[16:12]);
  endproperty
  a_index: assert property (p_index) else $error("plain set index wrong");

  property p_hash;
    @(posedge aclk) disable iff (!aresetn || !manual_rst_n)
    req_valid && ctrl_q[tlp_pkg::C_HASH]
      |=> s1_set_q == ($past(req_vaddr[16:12]) ^ $past(pehi_q[4:0]));
  endproperty
  a_hash: assert property (p_hash) else $error("hashed set index wrong");

  property p_bypass;
    @(posedge aclk) disable iff (!aresetn || !manual_rst_n)
    req_valid && req_vaddr[31:29] == tlp_pkg::AREA_P1 |-> ##2 !rsp_translated && !rsp_hit;
  endproperty
  a_bypass: assert property (p_bypass) else $error("fixed area was looked up");

  property p_miss;
    @(posedge aclk) disable iff (!aresetn || !manual_rst_n)
    rsp_translated |-> rsp_hit != rsp_miss;
  endproperty
  a_miss: assert property (p_miss) else $error("miss and hit disagree");

  property p_prio;
    @(posedge aclk) disable iff (!aresetn || !manual_rst_n)
    rsp_prot_viol |-> !rsp_initial_write && !rsp_cacheable && rsp_hit;
  endproperty
  a_prio: assert property (p_prio) else $error("violation not alone");

  property p_user_key;
    @(posedge aclk) disable iff (!aresetn || !manual_rst_n)
    s1_xlate_q && any_hit && !s1_priv_q && !key[1] |=> rsp_prot_viol;
  endproperty
  a_user_key: assert property (p_user_key) else $error("user access not refused");

  property p_flush;
    @(posedge aclk) disable iff (!aresetn)
    flush |=> valid_q == '0 ##1 !rsp_hit [*2];
  endproperty
  a_flush: assert property (p_flush) else $error("flush left entries in use");

  property p_cache;
    @(posedge aclk) disable iff (!aresetn || !manual_rst_n)
    rsp_translated && rsp_cacheable |-> rsp_hit && $past(sel[tlp_pkg::E_CACHE]);
  endproperty
  a_cache: assert property (p_cache) else $error("uncacheable page cached");

  c_hit: cover property (@(posedge aclk) rsp_hit && rsp_cacheable);
  c_miss: cover property (@(posedge aclk) rsp_miss);
  c_prot: cover property (@(posedge aclk) rsp_prot_viol);
  c_initw: cover property (@(posedge aclk) rsp_initial_write);
endmodule // tlp_lookup
`default_nettype wire

// ===== tlp_core_model.sv
// Core access path model: issues lookups and gathers the answers
`default_nettype none
module tlp_core_model (
  // Clock and power-on reset
  input wire logic aclk,
  input wire logic aresetn,
  // Access request
  output logic req_valid,
  output logic [31:0] req_vaddr,
  output logic req_write,
  output logic req_fetch,
  output logic privilege_mode_bit,
  // Answer, flags above the physical address
  input wire logic rsp_valid,
  input wire logic [38:0] rsp_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pipe_q = 2'h0;
  logic [38:0] got[$];
  int late = 0;
  // ==========================================================
  // Quiet bus at time zero
  initial
  begin
    req_valid = 1'b0;
    req_vaddr = 32'h0;
    req_write = 1'b0;
    req_fetch = 1'b0;
    privilege_mode_bit = 1'b1;
  end
  // Answer pulse must trail each request by exactly two edges
  always @(posedge aclk)
  begin
    pipe_q <= {pipe_q[0], req_valid};
    // Answer flops are unknown until the first reset edge
    if (aresetn && rsp_valid !== pipe_q[1]) late++;
    if (rsp_valid === 1'b1) got.push_back(rsp_bus);
  end
  // One access per call, back to back when called in a row
  task automatic issue(input logic [31:0] va, input logic wr, fe, pm);
    @(posedge aclk);
    req_valid <= 1'b1;
    req_vaddr <= va;
    req_write <= wr;
    req_fetch <= fe;
    privilege_mode_bit <= pm;
  endtask
  // Released address flips so a stale value cannot pass for a live one
  task automatic idle();
    @(posedge aclk);
    req_valid <= 1'b0;
    req_vaddr <= ~req_vaddr;
  endtask
endmodule // tlp_core_model
`default_nettype wire

// ===== tlp_lookup_tb.sv
// Self-checking bench for the translation lookup block
`default_nettype none
module tlp_lookup_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic mrst_n = 1'b1;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire logic awready, wready, bvalid, arready, rvalid, rq_v, rq_w, rq_f, rq_p, rv;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata, rq_a;
  wire logic [38:0] rsp;
  int n_mismatch = 0;
  int check_count = 0;
  // ==========================================================
  // Design and core model
  tlp_lookup u_dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .manual_rst_n(mrst_n),
    .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid),
    .s_axi_awready(awready),
    .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid),
    .s_axi_wready(wready),
    .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid),
    .s_axi_bready(bready),
    .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid),
    .s_axi_arready(arready),
    .s_axi_rdata(rdata),
    .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid),
    .s_axi_rready(rready),
    .req_valid(rq_v),
    .req_vaddr(rq_a),
    .req_write(rq_w),
    .req_fetch(rq_f),
    .privilege_mode_bit(rq_p),
    .rsp_valid(rv),
    .rsp_paddr(rsp[31:0]),
    .rsp_translated(rsp[38]),
    .rsp_fetch(rsp[37]),
    .rsp_hit(rsp[36]),
    .rsp_miss(rsp[35]),
    .rsp_prot_viol(rsp[34]),
    .rsp_initial_write(rsp[33]),
    .rsp_cacheable(rsp[32])
  );
  tlp_core_model u_core (
    .aclk(aclk),
    .aresetn(aresetn),
    .req_valid(rq_v),
    .req_vaddr(rq_a),
    .req_write(rq_w),
    .req_fetch(rq_f),
    .privilege_mode_bit(rq_p),
    .rsp_valid(rv),
    .rsp_bus(rsp)
  );
  // 40 MHz clock
  initial
  begin
    forever #12.5 aclk = ~aclk;
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [38:0] e, s);
    check_count++;
    if (e !== s)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic por();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  // Each channel drops valid at its own take; response closes the write
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 39'(er), 39'(bresp));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", 39'(ed), 39'(rdata));
    chk("rresp", 39'(er), 39'(rresp));
  endtask
  // Entry load: slot is way in 6:5 and set in 4:0
  task automatic ld(input logic [6:0] slot, input logic [31:0] hi, lo);
    wr(8'h08, hi);
    wr(8'h0c, lo);
    wr(8'h10, {25'h0, slot});
  endtask
  // Expected word: translated, fetch, hit, miss, prot, initial write, cacheable, address
  task automatic pop_chk(input logic [38:0] e, input bit pa = 1'b1);
    logic [38:0] s;
    s = 'x;
    if (u_core.got.size() > 0) s = u_core.got.pop_front();
    if (!pa) s[31:0] = e[31:0];
    chk("lookup", e, s);
  endtask
  task automatic look(input logic [31:0] va, input logic w, p, input logic [38:0] e,
      input bit pa = 1'b1);
    u_core.issue(va, w, 1'b0, p);
    u_core.idle();
    repeat (3) @(posedge aclk);
    pop_chk(e, pa);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h20, 32'h0, 2'h2);
    wr(8'h20, 32'h1, 2'h2);
    look(32'h0001_2c24, 1'b0, 1'b1, {7'h01, 32'h0001_2c24});
    wr(8'h00, 32'h1);
    look(32'h0001_2c24, 1'b0, 1'b1, {7'h48, 32'h0});
  endtask
  task automatic t_small();
    ld(7'h52, 32'h0001_2c00, 32'h0034_516e);
    look(32'h0001_2c24, 1'b0, 1'b1, {7'h51, 32'h0034_5024});
    // Four accesses in consecutive cycles
    u_core.issue(32'h0001_2824, 1'b0, 1'b0, 1'b1);
    u_core.issue(32'hc001_2c24, 1'b0, 1'b0, 1'b1);
    u_core.issue(32'h8001_2c24, 1'b0, 1'b1, 1'b1);
    u_core.issue(32'ha001_2c24, 1'b0, 1'b0, 1'b1);
    u_core.idle();
    repeat (3) @(posedge aclk);
    pop_chk({7'h48, 32'h0});
    pop_chk({7'h48, 32'h0});
    pop_chk({7'h21, 32'h0001_2c24});
    pop_chk({7'h00, 32'h0001_2c24});
  endtask
  task automatic t_big();
    ld(7'h25, 32'h0000_5000, 32'h0067_8d7e);
    look(32'h0000_5448, 1'b0, 1'b1, {7'h51, 32'h0067_8448});
    rd(8'h14, 32'h51, 2'h0);
    rd(8'h18, 32'hc001_2c24, 2'h0);
  endtask
  task automatic t_tags();
    wr(8'h04, 32'hb5);
    ld(7'h63, 32'h0000_3035, 32'h0011_116c);
    look(32'h0000_3010, 1'b0, 1'b1, {7'h48, 32'h0});
    wr(8'h04, 32'h35);
    look(32'h0000_3010, 1'b0, 1'b1, {7'h51, 32'h0011_1010});
    wr(8'h04, 32'hb5);
    wr(8'h00, 32'h5);
    look(32'h0000_3010, 1'b0, 1'b1, {7'h51, 32'h0011_1010});
    look(32'h0000_3010, 1'b0, 1'b0, {7'h48, 32'h0});
    wr(8'h00, 32'h1);
    ld(7'h63, 32'h0000_3035, 32'h0011_116e);
    look(32'h0000_3010, 1'b0, 1'b0, {7'h51, 32'h0011_1010});
  endtask
  task automatic t_hash();
    wr(8'h00, 32'h3);
    rd(8'h00, 32'h3, 2'h0);
    wr(8'h04, 32'h13);
    ld(7'h14, 32'h0000_7013, 32'h0022_216e);
    look(32'h0000_7000, 1'b0, 1'b1, {7'h51, 32'h0022_2000});
    wr(8'h00, 32'h1);
    look(32'h0000_7000, 1'b0, 1'b1, {7'h48, 32'h0});
  endtask
  // Every key, dirty, cacheable, mode and direction
  task automatic t_rights();
    logic [1:0] k;
    logic c, dw, p, w, ok, iw;
    logic [31:0] lo;
    logic [38:0] ex;
    wr(8'h04, 32'h0);
    for (int i = 0; i < 64; i++)
    begin
      {c, k, dw, p, w} = 6'(i);
      ok = w ? (k[0] & (p | k[1])) : (p | k[1]);
      iw = ok & w & !dw;
      // In-use set, small global page
      lo = {22'h000d14, 3'h2, k, 1'b0, c, dw, 2'h2};
      ex = {4'ha, !ok, iw, ok & !iw & c, 32'h0034_5024};
      ld(7'h52, 32'h0001_2c00, lo);
      look(32'h0001_2c24, w, p, ex);
    end
  endtask
  task automatic t_manual();
    ld(7'h52, 32'h0001_2c00, 32'h0034_516e);
    @(posedge aclk);
    mrst_n <= 1'b0;
    repeat (2) @(posedge aclk);
    mrst_n <= 1'b1;
    rd(8'h00, 32'h0, 2'h0);
    wr(8'h00, 32'h1);
    look(32'h0001_2c24, 1'b0, 1'b1, {7'h51, 32'h0034_5024});
    wr(8'h00, 32'h9);
    rd(8'h00, 32'h1, 2'h0);
    look(32'h0001_2c24, 1'b0, 1'b1, {7'h48, 32'h0});
    ld(7'h52, 32'h0001_2c00, 32'h0034_516e);
    por();
    wr(8'h00, 32'h1);
    look(32'h0001_2c24, 1'b0, 1'b1, {7'h48, 32'h0});
  endtask
  // ==========================================================
  // Main sequence and hang guard
  initial
  begin
    por();
    t_reset();
    $display("t_reset done");
    t_small();
    $display("t_small done");
    t_big();
    $display("t_big done");
    t_tags();
    $display("t_tags done");
    t_hash();
    $display("t_hash done");
    t_rights();
    $display("t_rights done");
    t_manual();
    $display("t_manual done");
    chk("latency", 39'h0, 39'(u_core.late));
    close_out();
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    close_out();
  end
endmodule // tlp_lookup_tb
`default_nettype wire
